// ==== hdl/tbp_pkg.sv ====
// Shared constants and helpers for the time-division backplane port.
// Assumes a 50 MHz system clock that oversamples every backplane clock.
package tbp_pkg;

  localparam int          N_LINKS      = 4;
  localparam longint      SYS_CLK_HZ   = 64'd50000000;
  localparam longint      T1_CLK_HZ    = 64'd1544000;
  localparam longint      E1_CLK_HZ    = 64'd2048000;
  localparam int          NCO_W        = 16;
  localparam logic [15:0] NCO_T1_INC   = 16'(((T1_CLK_HZ << NCO_W) + SYS_CLK_HZ / 2) / SYS_CLK_HZ);
  localparam logic [15:0] NCO_E1_INC   = 16'(((E1_CLK_HZ << NCO_W) + SYS_CLK_HZ / 2) / SYS_CLK_HZ);
  localparam int          NCO_MSB      = NCO_W - 1;

  // Frame geometry in backplane bits
  localparam logic [7:0]  T1_LAST      = 8'hC0;
  localparam logic [7:0]  E1_LAST      = 8'hFF;
  localparam logic [4:0]  T1_MF_LAST   = 5'h17;
  localparam logic [4:0]  E1_MF_LAST   = 5'h0F;
  localparam logic [4:0]  SF_HALF      = 5'h0C;
  localparam logic [4:0]  TS_OVH_A     = 5'h01;
  localparam logic [4:0]  TS_OVH_B     = 5'h10;
  localparam logic [2:0]  SIG_POS_LO   = 3'h4;
  localparam logic [2:0]  POS_LAST     = 3'h7;
  localparam logic [7:0]  T1_FIRST_END = 8'h08;
  localparam logic [7:0]  E1_FIRST_END = 8'h07;

  // Master frame pulse selections
  localparam logic [2:0]  FP_EVERY     = 3'h0;
  localparam logic [2:0]  FP_ALT       = 3'h1;
  localparam logic [2:0]  FP_MF        = 3'h2;
  localparam logic [2:0]  FP_MF_BOTH   = 3'h3;
  localparam logic [2:0]  FP_TS_OVH    = 3'h4;

  // Bit count after one backplane clock edge
  function automatic logic [7:0] tbp_adv(input logic e1, input logic [7:0] cnt);
    return (cnt == (e1 ? E1_LAST : T1_LAST)) ? 8'h00 : cnt + 8'h01;
  endfunction : tbp_adv

  // Bit position inside the timeslot; T1 skips the F-bit
  function automatic logic [2:0] tbp_pos(input logic e1, input logic [7:0] cnt);
    logic [7:0] c;
    c = e1 ? cnt : cnt - 8'h01;
    return c[2:0];
  endfunction : tbp_pos

  // Frame count after a frame wrap
  function automatic logic [4:0] tbp_frm(input logic e1, input logic [7:0] cnt, input logic [4:0] frm);
    if (cnt != 8'h00)
      return frm;
    return (frm == (e1 ? E1_MF_LAST : T1_MF_LAST)) ? 5'h00 : frm + 5'h01;
  endfunction : tbp_frm

endpackage : tbp_pkg

// ==== hdl/tbp_port.sv ====
// What this block does
// - Master receive data follows own link clock
// - Slave receive clock: own or link 1
// - Mux receive data interleaved, A equals B
// - Mux receive outputs follow mux clock
// - Signaling in b5-b8, timeslot aligned
// - Signaling updates on data clock edges
// - Mux signaling interleaved, A equals B
// - T1 master frame pulse points selectable
// - E1 master frame pulse points selectable
// - Frame pulse on link clock, invertible
// - Mux frame pulse sampled, invertible
// - Master clock out 1.544 or 2.048 MHz
// - Master transmit data sampled on own clock
// - Slave transmit clock: own or link 1
// - Mux transmit data from A or B
// - Transmit signaling b5-b8 with data
// - Transmit frame pulse driven or sampled
// Four-link system-side backplane port; core side is parallel bytes.
// Assumes backplane pins arrive asynchronous; configuration is on sys_clk_i.
`timescale 1ns/1ps
module tbp_port
  import tbp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Configuration: one bit per link, three bits per link for rx_fp_sel_i, and single bits for mux and output enable
  input  wire logic [3:0]  e1_mode_i,
  input  wire logic [3:0]  t1_esf_i,
  input  wire logic [3:0]  rx_master_i,
  input  wire logic [3:0]  rx_slave_clock_select_i,
  input  wire logic [3:0]  rx_frame_pulse_invert_i,
  input  wire logic [11:0] rx_fp_sel_i,
  input  wire logic [3:0]  tx_master_i,
  input  wire logic [3:0]  tx_slave_clock_select_i,
  input  wire logic [3:0]  tx_frame_pulse_invert_i,
  input  wire logic        rx_mux_i,
  input  wire logic        tx_mux_i,
  input  wire logic        mux_tx_use_b_i,
  input  wire logic        rx_output_enable_i,
  // Core receive side
  input  wire logic [31:0] core_rx_data_i,
  input  wire logic [15:0] core_rx_sig_i,
  output logic      [3:0]  core_rx_take_o,
  // Core transmit side
  output logic      [31:0] core_tx_data_o,
  output logic      [15:0] core_tx_sig_o,
  output logic      [3:0]  core_tx_valid_o,
  output logic      [3:0]  core_tx_first_o,
  // Receive backplane pins
  output logic      [3:0]  rx_sys_data_o,
  output logic      [3:0]  rx_sys_data_oe_o,
  output logic      [3:0]  rx_sys_signaling_o,
  output logic      [3:0]  rx_sys_signaling_oe_o,
  input  wire logic [3:0]  rx_sys_clock_i,
  output logic      [3:0]  rx_sys_clock_o,
  output logic      [3:0]  rx_sys_clock_oe_o,
  input  wire logic [3:0]  rx_sys_frame_pulse_i,
  output logic      [3:0]  rx_sys_frame_pulse_o,
  output logic      [3:0]  rx_sys_frame_pulse_oe_o,
  // Receive multiplexed pins
  input  wire logic        mux_rx_clock_i,
  input  wire logic        mux_rx_frame_pulse_i,
  output logic             mux_rx_data_a_o,
  output logic             mux_rx_data_b_o,
  output logic             mux_rx_signaling_a_o,
  output logic             mux_rx_signaling_b_o,
  output logic             mux_rx_oe_o,
  // Transmit backplane pins
  input  wire logic [3:0]  tx_sys_data_i,
  input  wire logic [3:0]  tx_sys_signaling_i,
  input  wire logic [3:0]  tx_sys_clock_i,
  output logic      [3:0]  tx_sys_clock_o,
  output logic      [3:0]  tx_sys_clock_oe_o,
  input  wire logic [3:0]  tx_sys_frame_pulse_i,
  output logic      [3:0]  tx_sys_frame_pulse_o,
  output logic      [3:0]  tx_sys_frame_pulse_oe_o,
  // Transmit multiplexed pins
  input  wire logic        mux_tx_clock_i,
  input  wire logic        mux_tx_data_a_i,
  input  wire logic        mux_tx_data_b_i,
  input  wire logic        mux_tx_signaling_a_i,
  input  wire logic        mux_tx_signaling_b_i
);

  localparam int SYNC_W = 31;

  typedef struct packed {
    logic [3:0][15:0] acc;
    logic [3:0][7:0]  rcnt;
    logic [3:0][4:0]  rfrm;
    logic [3:0][7:0]  rsh;
    logic [3:0][3:0]  rx_sys_signaling;
    logic [3:0]       rdat;
    logic [3:0]       rsigo;
    logic [3:0]       rfp;
    logic [3:0]       take;
    logic [3:0][7:0]  tcnt;
    logic [3:0][7:0]  tsh;
    logic [3:0][3:0]  tx_sys_signaling;
    logic [3:0]       tfp;
    logic [3:0][7:0]  tbyte;
    logic [3:0][3:0]  tnib;
    logic [3:0]       tval;
    logic [3:0]       tfirst;
    logic [9:0]       mcnt;
    logic [7:0]       msh;
    logic [3:0]       msig;
    logic             mdat;
    logic             msigo;
    logic [9:0]       mtcnt;
    logic [7:0]       mtsh;
    logic [3:0]       mtsig;
  } tbp_state_t;

  tbp_state_t          st;
  tbp_state_t          next_st;
  logic [SYNC_W-1:0]   sync_in;
  logic [SYNC_W-1:0]   sync_lvl;
  logic [SYNC_W-1:0]   sync_rise;
  logic [3:0]          rclk_r;
  logic [3:0]          rfp_l;
  logic [3:0]          tclk_r;
  logic [3:0]          tfp_l;
  logic [3:0]          td_l;
  logic [3:0]          ts_l;
  logic                mrclk_r;
  logic                mrfp_l;
  logic                mtclk_r;
  logic                mta_l;
  logic                mtb_l;
  logic                mtsa_l;
  logic                mtsb_l;

  // All backplane inputs pass the same two stages, keeping data aligned with clocks
  assign sync_in = {mux_tx_signaling_b_i, mux_tx_signaling_a_i, mux_tx_data_b_i, mux_tx_data_a_i,
                    mux_tx_clock_i, mux_rx_frame_pulse_i, mux_rx_clock_i, tx_sys_signaling_i,
                    tx_sys_data_i, tx_sys_frame_pulse_i, tx_sys_clock_i, rx_sys_frame_pulse_i,
                    rx_sys_clock_i};

  tbp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (sync_in),
    .level_o   (sync_lvl),
    .rise_o    (sync_rise)
  );

  assign rclk_r  = sync_rise[3:0];
  assign rfp_l   = sync_lvl[7:4];
  assign tclk_r  = sync_rise[11:8];
  assign tfp_l   = sync_lvl[15:12];
  assign td_l    = sync_lvl[19:16];
  assign ts_l    = sync_lvl[23:20];
  assign mrclk_r = sync_rise[24];
  assign mrfp_l  = sync_lvl[25];
  assign mtclk_r = sync_rise[26];
  assign mta_l   = sync_lvl[27];
  assign mtb_l   = sync_lvl[28];
  assign mtsa_l  = sync_lvl[29];
  assign mtsb_l  = sync_lvl[30];

  // Master frame pulse point decode
  function automatic logic fp_hit(input logic e1, input logic esf, input logic [2:0] sel,
                                  input logic [7:0] c, input logic [4:0] frm);
    logic f0;
    f0 = (c == 8'h00);
    if (e1) begin
      unique case (sel)
        FP_EVERY:                 return f0;
        FP_ALT, FP_MF, FP_MF_BOTH: return f0 && (frm == 5'h00);
        FP_TS_OVH:                return (c[7:3] == TS_OVH_A) || (c[7:3] == TS_OVH_B);
        default:                  return 1'b0;
      endcase
    end
    unique case (sel)
      FP_EVERY:   return f0;
      FP_ALT:     return f0 && !frm[0];
      FP_MF:      return f0 && ((frm == 5'h00) || (!esf && frm == SF_HALF));
      FP_MF_BOTH: return f0 && (frm == 5'h00);
      default:    return 1'b0;
    endcase
  endfunction : fp_hit

  always_comb begin
    logic [15:0] acc_n;
    logic        nco_r;
    logic        edge_r;
    logic        edge_t;
    logic        fp_act;
    logic [7:0]  c;
    logic [2:0]  pos;
    logic        fb;
    logic [7:0]  byte_v;
    logic [1:0]  lk;
    acc_n   = '0;
    nco_r   = 1'b0;
    edge_r  = 1'b0;
    edge_t  = 1'b0;
    fp_act  = 1'b0;
    c       = '0;
    pos     = '0;
    fb      = 1'b0;
    byte_v  = '0;
    lk      = '0;
    next_st      = st;
    next_st.take = '0;
    next_st.tval = '0;
    for (int l = 0; l < N_LINKS; l++) begin
      // Fractional divider makes the master clock, gapped by phase steps
      acc_n = st.acc[l] + (e1_mode_i[l] ? NCO_E1_INC : NCO_T1_INC);
      nco_r = !st.acc[l][NCO_MSB] && acc_n[NCO_MSB];
      next_st.acc[l] = acc_n;
      edge_r = rx_master_i[l] ? nco_r : (rx_slave_clock_select_i[l] ? rclk_r[0] : rclk_r[l]);
      edge_t = tx_master_i[l] ? nco_r : (tx_slave_clock_select_i[l] ? tclk_r[0] : tclk_r[l]);
      // Receive link
      if (edge_r && !rx_mux_i) begin
        fp_act = !rx_master_i[l] && (rfp_l[l] ^ rx_frame_pulse_invert_i[l]);
        c      = fp_act ? 8'h00 : tbp_adv(e1_mode_i[l], st.rcnt[l]);
        pos    = tbp_pos(e1_mode_i[l], c);
        fb     = !e1_mode_i[l] && (c == 8'h00);
        next_st.rcnt[l] = c;
        next_st.rfrm[l] = tbp_frm(e1_mode_i[l], c, st.rfrm[l]);
        next_st.rsigo[l] = 1'b0;
        if (fb) begin
          next_st.rdat[l] = 1'b0;
        end else if (pos == 3'h0) begin
          byte_v = core_rx_data_i[l*8 +: 8];
          next_st.rdat[l] = byte_v[7];
          next_st.rsh[l]  = {byte_v[6:0], 1'b0};
          next_st.rx_sys_signaling[l] = core_rx_sig_i[l*4 +: 4];
          next_st.take[l] = 1'b1;
        end else begin
          next_st.rdat[l] = st.rsh[l][7];
          next_st.rsh[l]  = {st.rsh[l][6:0], 1'b0};
          if (pos >= SIG_POS_LO) begin
            next_st.rsigo[l] = st.rx_sys_signaling[l][2'(POS_LAST - pos)];
          end
        end
        next_st.rfp[l] = rx_master_i[l] &&
                         fp_hit(e1_mode_i[l], t1_esf_i[l], rx_fp_sel_i[l*3 +: 3], c, next_st.rfrm[l]);
      end
      // Transmit link
      if (edge_t && !tx_mux_i) begin
        fp_act = !tx_master_i[l] && (tfp_l[l] ^ tx_frame_pulse_invert_i[l]);
        c      = fp_act ? 8'h00 : tbp_adv(e1_mode_i[l], st.tcnt[l]);
        pos    = tbp_pos(e1_mode_i[l], c);
        fb     = !e1_mode_i[l] && (c == 8'h00);
        next_st.tcnt[l] = c;
        next_st.tfp[l]  = tx_master_i[l] && (c == 8'h00);
        if (!fb) begin
          next_st.tsh[l] = {st.tsh[l][6:0], td_l[l]};
          if (pos >= SIG_POS_LO) begin
            next_st.tx_sys_signaling[l] = {st.tx_sys_signaling[l][2:0], ts_l[l]};
          end
          if (pos == POS_LAST) begin
            next_st.tbyte[l]  = {st.tsh[l][6:0], td_l[l]};
            next_st.tnib[l]   = {st.tx_sys_signaling[l][2:0], ts_l[l]};
            next_st.tval[l]   = 1'b1;
            next_st.tfirst[l] = (c == (e1_mode_i[l] ? E1_FIRST_END : T1_FIRST_END));
          end
        end
      end
    end
    // Receive multiplexed bus, slot order link 1..4 within each timeslot
    if (mrclk_r && rx_mux_i) begin
      fp_act = mrfp_l ^ rx_frame_pulse_invert_i[0];
      next_st.mcnt = fp_act ? 10'h000 : st.mcnt + 10'h001;
      lk  = next_st.mcnt[4:3];
      pos = next_st.mcnt[2:0];
      next_st.msigo = 1'b0;
      if (pos == 3'h0) begin
        byte_v = core_rx_data_i[lk*8 +: 8];
        next_st.mdat     = byte_v[7];
        next_st.msh      = {byte_v[6:0], 1'b0};
        next_st.msig     = core_rx_sig_i[lk*4 +: 4];
        next_st.take[lk] = 1'b1;
      end else begin
        next_st.mdat = st.msh[7];
        next_st.msh  = {st.msh[6:0], 1'b0};
        if (pos >= SIG_POS_LO) begin
          next_st.msigo = st.msig[2'(POS_LAST - pos)];
        end
      end
    end
    // Transmit multiplexed bus, A or B chosen by configuration
    if (mtclk_r && tx_mux_i) begin
      fp_act = tfp_l[0] ^ tx_frame_pulse_invert_i[0];
      c = 8'h00;
      next_st.mtcnt = fp_act ? 10'h000 : st.mtcnt + 10'h001;
      lk  = next_st.mtcnt[4:3];
      pos = next_st.mtcnt[2:0];
      next_st.mtsh = {st.mtsh[6:0], mux_tx_use_b_i ? mtb_l : mta_l};
      if (pos >= SIG_POS_LO) begin
        next_st.mtsig = {st.mtsig[2:0], mux_tx_use_b_i ? mtsb_l : mtsa_l};
      end
      if (pos == POS_LAST) begin
        next_st.tbyte[lk]  = {st.mtsh[6:0], mux_tx_use_b_i ? mtb_l : mta_l};
        next_st.tnib[lk]   = {st.mtsig[2:0], mux_tx_use_b_i ? mtsb_l : mtsa_l};
        next_st.tval[lk]   = 1'b1;
        next_st.tfirst[lk] = (next_st.mtcnt[9:5] == 5'h00);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Core side
  assign core_rx_take_o  = st.take;
  assign core_tx_data_o  = st.tbyte;
  assign core_tx_sig_o   = st.tnib;
  assign core_tx_valid_o = st.tval;
  assign core_tx_first_o = st.tfirst;

  // Receive pins; data floats when disabled or in multiplexed mode
  assign rx_sys_data_o           = st.rdat;
  assign rx_sys_signaling_o      = st.rsigo;
  assign rx_sys_data_oe_o        = {4{rx_output_enable_i && !rx_mux_i}};
  assign rx_sys_signaling_oe_o   = {4{rx_output_enable_i && !rx_mux_i}};
  assign rx_sys_frame_pulse_o    = st.rfp ^ rx_frame_pulse_invert_i;
  assign rx_sys_frame_pulse_oe_o = rx_master_i & {4{!rx_mux_i}};

  // Master clocks straight from divider flops
  for (genvar g = 0; g < N_LINKS; g++) begin : g_clk
    assign rx_sys_clock_o[g] = st.acc[g][NCO_MSB];
    assign tx_sys_clock_o[g] = st.acc[g][NCO_MSB];
  end
  assign rx_sys_clock_oe_o       = rx_master_i & {4{!rx_mux_i}};
  assign tx_sys_clock_oe_o       = tx_master_i & {4{!tx_mux_i}};
  assign tx_sys_frame_pulse_o    = st.tfp ^ tx_frame_pulse_invert_i;
  assign tx_sys_frame_pulse_oe_o = tx_master_i & {4{!tx_mux_i}};

  // Multiplexed receive; B mirrors A as a backup
  assign mux_rx_data_a_o      = st.mdat;
  assign mux_rx_data_b_o      = st.mdat;
  assign mux_rx_signaling_a_o = st.msigo;
  assign mux_rx_signaling_b_o = st.msigo;
  assign mux_rx_oe_o          = rx_output_enable_i && rx_mux_i;

endmodule : tbp_port

// ==== hdl/tbp_sync.sv ====
// Two-stage synchroniser with rising-edge detect behind the second stage.
// Assumes inputs asynchronous to sys_clk_i and slower than a third of it.
`timescale 1ns/1ps
module tbp_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  // Asynchronous inputs
  input  wire logic [W-1:0] async_i,
  // Synchronised level and rising edge
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o
);

  if (W < 1) begin : g_chk
    $error("tbp_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tbp_sync_t;

  tbp_sync_t st;
  tbp_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.s2;
  assign rise_o  = st.s2 & ~st.s3;

endmodule : tbp_sync

// ==== sim/tb_top.sv ====
// Self-checking bench for the backplane port against the far-side model.
// Assumes the checker is bound to every tbp_port instance.
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [3:0]  e1_mode_i = 4'hF, t1_esf_i = 4'h0, rx_master_i = 4'h0, rx_slave_clock_select_i = 4'h2;
  logic [3:0]  rx_frame_pulse_invert_i = 4'h0, tx_master_i = 4'h0, tx_slave_clock_select_i = 4'h0;
  logic [3:0]  tx_frame_pulse_invert_i = 4'h0;
  logic [11:0] rx_fp_sel_i = 12'h000;
  logic        rx_mux_i = 1'b0, tx_mux_i = 1'b0, mux_tx_use_b_i = 1'b0, rx_output_enable_i = 1'b0;
  logic [31:0] core_rx_data_i = 32'hD4C3B2A1;
  logic [15:0] core_rx_sig_i = 16'h8429;
  logic [31:0] core_tx_data_o;
  logic [15:0] core_tx_sig_o;
  logic [3:0]  core_tx_valid_o, core_tx_first_o, rx_sys_data_o, rx_sys_signaling_o, rx_sys_clock_o;
  logic [3:0]  rx_sys_clock_oe_o, rx_sys_frame_pulse_o, rx_sys_frame_pulse_oe_o;
  logic [3:0]  tx_sys_clock_o, tx_sys_clock_oe_o, tx_sys_frame_pulse_o, tx_sys_frame_pulse_oe_o;
  logic        mux_rx_data_a_o, mux_rx_signaling_a_o;
  int          errors = 0;
  int          samples_checked = 0;

  tbp_far_end far ();

  // Pin levels from every party's enable; idle pins pulled up
  wire [3:0] rx_ck_w = (rx_sys_clock_oe_o & rx_sys_clock_o) | (~rx_sys_clock_oe_o & {3'b111, far.clk});
  wire [3:0] rx_fp_w = (rx_sys_frame_pulse_oe_o & rx_sys_frame_pulse_o) | (~rx_sys_frame_pulse_oe_o & {4{far.fp}});
  wire [3:0] tx_ck_w = (tx_sys_clock_oe_o & tx_sys_clock_o) | (~tx_sys_clock_oe_o & {far.clk, 3'b111});
  wire [3:0] tx_fp_w = (tx_sys_frame_pulse_oe_o & tx_sys_frame_pulse_o) | (~tx_sys_frame_pulse_oe_o & {4{far.fp}});

  tbp_port DUT (.sys_clk_i, .rstn_i, .e1_mode_i, .t1_esf_i, .rx_master_i, .rx_slave_clock_select_i,
    .rx_frame_pulse_invert_i, .rx_fp_sel_i, .tx_master_i, .tx_slave_clock_select_i, .tx_frame_pulse_invert_i,
    .rx_mux_i, .tx_mux_i, .mux_tx_use_b_i, .rx_output_enable_i, .core_rx_data_i, .core_rx_sig_i,
    .core_rx_take_o(), .core_tx_data_o, .core_tx_sig_o, .core_tx_valid_o, .core_tx_first_o, .rx_sys_data_o,
    .rx_sys_data_oe_o(), .rx_sys_signaling_o, .rx_sys_signaling_oe_o(), .rx_sys_clock_i(rx_ck_w),
    .rx_sys_clock_o, .rx_sys_clock_oe_o, .rx_sys_frame_pulse_i(rx_fp_w), .rx_sys_frame_pulse_o,
    .rx_sys_frame_pulse_oe_o, .mux_rx_clock_i(far.clk), .mux_rx_frame_pulse_i(far.fp), .mux_rx_data_a_o,
    .mux_rx_data_b_o(), .mux_rx_signaling_a_o, .mux_rx_signaling_b_o(), .mux_rx_oe_o(),
    .tx_sys_data_i({far.dat, 3'b000}), .tx_sys_signaling_i({far.sig, 3'b000}), .tx_sys_clock_i(tx_ck_w),
    .tx_sys_clock_o, .tx_sys_clock_oe_o, .tx_sys_frame_pulse_i(tx_fp_w), .tx_sys_frame_pulse_o,
    .tx_sys_frame_pulse_oe_o, .mux_tx_clock_i(far.clk), .mux_tx_data_a_i(!far.dat), .mux_tx_data_b_i(far.dat),
    .mux_tx_signaling_a_i(!far.sig), .mux_tx_signaling_b_i(far.sig));

  always #10 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("errors %0d, samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // Multiplexed receive: four links interleaved, link 1 first
  task automatic mux_rx();
    rx_mux_i <= 1'b1;
    @(posedge sys_clk_i);
    fork
      far.frame(32, 1'b1, 32'h0, 16'h0);
      for (int i = 0; i < 32; i++) begin
        @(posedge far.clk);
        repeat (6) @(posedge sys_clk_i);
        chk(mux_rx_data_a_o, core_rx_data_i[8 * (i / 8) + 7 - i % 8]);
        chk(mux_rx_signaling_a_o, (i % 8 > 3) ? core_rx_sig_i[4 * (i / 8) + 7 - i % 8] : 1'b0);
      end
    join
    rx_mux_i <= 1'b0;
  endtask : mux_rx

  // Slave links 1 and 2 on link 1 clock, both pulse polarities
  task automatic rx_slave();
    for (int inv = 0; inv < 2; inv++) begin
      rx_frame_pulse_invert_i <= {4{inv[0]}};
      @(posedge sys_clk_i);
      fork
        far.frame(16, !inv[0], 32'h0, 16'h0);
        for (int i = 0; i < 16; i++) begin
          @(posedge far.clk);
          repeat (6) @(posedge sys_clk_i);
          chk(rx_sys_data_o[0], core_rx_data_i[7 - i % 8]);
          chk(rx_sys_data_o[1], core_rx_data_i[15 - i % 8]);
          chk(rx_sys_signaling_o[0], (i % 8 > 3) ? core_rx_sig_i[7 - i % 8] : 1'b0);
          chk(rx_sys_signaling_o[1], (i % 8 > 3) ? core_rx_sig_i[11 - i % 8] : 1'b0);
        end
      join
    end
  endtask : rx_slave

  // Slave transmit link 4: byte and signaling reach the core
  task automatic tx_slave();
    int n = 0;
    fork
      far.frame(8, 1'b1, 32'h96969696, 16'hBBBB);
      while (core_tx_valid_o[3] !== 1'b1 && n < 200) begin
        @(posedge sys_clk_i);
        n++;
      end
    join
    chk(core_tx_data_o[31:24], 8'h96);
    chk(core_tx_sig_o[15:12], 4'hB);
    chk(core_tx_first_o[3], 1'b1);
  endtask : tx_slave

  // Multiplexed transmit from B: second byte lands on link 2 lane
  task automatic mux_tx();
    tx_mux_i <= 1'b1;
    mux_tx_use_b_i <= 1'b1;
    @(posedge sys_clk_i);
    far.frame(16, 1'b1, 32'h3CA50000, 16'h0600);
    chk(core_tx_data_o[15:8], 8'hA5);
    chk(core_tx_sig_o[7:4], 4'h6);
    chk(core_tx_first_o[1], 1'b1);
    tx_mux_i <= 1'b0;
  endtask : mux_tx

  // Master link 3: frame pulse spacing in clock edges and time
  task automatic rx_master();
    int  edges, cyc;
    logic ck, fp;
    rx_master_i <= 4'h4;
    tx_master_i <= 4'h4;
    t1_esf_i <= 4'hF;
    rx_frame_pulse_invert_i <= 4'h0;
    for (int k = 0; k < 3; k++) begin
      e1_mode_i[2] <= (k == 2);
      rx_fp_sel_i[8:6] <= (k == 1) ? 3'h1 : 3'h0;
      for (int p = 0; p < 2; p++) begin
        edges = 0;
        cyc = 0;
        do begin
          ck = rx_sys_clock_o[2];
          fp = rx_sys_frame_pulse_o[2];
          @(posedge sys_clk_i);
          cyc++;
          if (!ck && rx_sys_clock_o[2]) edges++;
        end while (!(!fp && rx_sys_frame_pulse_o[2] === 1'b1) && cyc < 30000);
      end
      chk(edges, (k == 0) ? 193 : ((k == 1) ? 386 : 256));
      chk((cyc + 5) / 10, (k == 1) ? 1250 : 625);
    end
  endtask : rx_master

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rx_output_enable_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    mux_rx();
    rx_slave();
    tx_slave();
    mux_tx();
    rx_master();
    tally_and_finish();
  end

  initial begin
    repeat (80000) @(posedge sys_clk_i);
    errors++;
    tally_and_finish();
  end
endmodule : tb_top

// ==== sim/tbp_far_end.sv ====
// Far-side system logic: slave clock, frame pulse, serial data and signaling.
// Assumes calls to frame() start just after a rising sys_clk_i edge.
`timescale 1ns/1ps
module tbp_far_end;
  logic clk = 1'b0;
  logic fp  = 1'b1;
  logic dat = 1'b0;
  logic sig = 1'b0;

  // Burst of n bits at 160 ns; clock stands still between bursts
  task automatic frame(input int n, input logic act, input logic [31:0] w, input logic [15:0] s);
    int b;
    for (int i = 0; i < n; i++) begin
      b = i % 32;
      fp  <= (i == 0) ? act : !act;
      dat <= w[31 - b];
      sig <= (b % 8 > 3) ? s[15 - 4 * (b / 8) - (b % 8 - 4)] : 1'b0;
      #80 clk <= 1'b1;
      #80 clk <= 1'b0;
    end
    fp  <= 1'b1;
    dat <= !dat;
    sig <= !sig;
  endtask : frame
endmodule : tbp_far_end

// ==== sim/tbp_port_monitor.sv ====
// Checker on the backplane port pins and core strobes.
// Assumes it is bound to every tbp_port instance.
`timescale 1ns/1ps
module tbp_port_monitor (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  // Configuration
  input wire logic [3:0] rx_master_i,
  input wire logic [3:0] rx_slave_clock_select_i,
  input wire logic [3:0] tx_master_i,
  input wire logic       rx_mux_i,
  input wire logic       tx_mux_i,
  input wire logic       rx_output_enable_i,
  // Backplane pins
  input wire logic [3:0] rx_sys_clock_i,
  input wire logic [3:0] rx_sys_data_o,
  input wire logic [3:0] rx_sys_data_oe_o,
  input wire logic [3:0] rx_sys_signaling_oe_o,
  input wire logic [3:0] rx_sys_clock_oe_o,
  input wire logic [3:0] tx_sys_frame_pulse_oe_o,
  input wire logic       mux_rx_data_a_o,
  input wire logic       mux_rx_data_b_o,
  input wire logic       mux_rx_signaling_a_o,
  input wire logic       mux_rx_signaling_b_o,
  input wire logic       mux_rx_oe_o,
  // Core strobes
  input wire logic [3:0] core_rx_take_o,
  input wire logic [3:0] core_tx_valid_o
);
  logic       clk0_seen;
  logic [3:0] lag;

  // Cycles since link 1 clock pin rose, saturating
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk0_seen <= 1'b0;
      lag       <= 4'hF;
    end else begin
      clk0_seen <= rx_sys_clock_i[0];
      lag       <= (rx_sys_clock_i[0] && !clk0_seen) ? 4'h0 : ((lag == 4'hF) ? lag : lag + 4'h1);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_mux_data_twin: assert property (mux_rx_data_a_o == mux_rx_data_b_o)
    else $error("mux data outputs differ");
  a_mux_sig_twin: assert property (mux_rx_signaling_a_o == mux_rx_signaling_b_o)
    else $error("mux signaling outputs differ");
  a_rx_float_off: assert property (!rx_output_enable_i |-> (rx_sys_data_oe_o == 4'h0 && rx_sys_signaling_oe_o == 4'h0 && !mux_rx_oe_o))
    else $error("receive outputs driven while disabled");
  a_rx_clock_dir: assert property (rx_sys_clock_oe_o == (rx_master_i & {4{!rx_mux_i}}))
    else $error("receive clock direction wrong");
  a_tx_pulse_dir: assert property (tx_sys_frame_pulse_oe_o == (tx_master_i & {4{!tx_mux_i}}))
    else $error("transmit pulse direction wrong");
  a_take_single: assert property (core_rx_take_o[0] |=> !core_rx_take_o[0])
    else $error("receive take longer than one cycle");
  a_valid_single: assert property (core_tx_valid_o[3] |=> !core_tx_valid_o[3])
    else $error("transmit valid longer than one cycle");
  a_own_clock_lag: assert property ((!rx_master_i[0] && !rx_mux_i && $changed(rx_sys_data_o[0])) |-> (lag >= 4'h2 && lag <= 4'h5))
    else $error("link 1 data moved off its clock edge");
  a_shared_clock_lag: assert property ((!rx_master_i[1] && rx_slave_clock_select_i[1] && !rx_mux_i && $changed(rx_sys_data_o[1])) |-> (lag >= 4'h2 && lag <= 4'h5))
    else $error("link 2 data moved off link 1 clock edge");
endmodule : tbp_port_monitor

bind tbp_port tbp_port_monitor u_mon (.sys_clk_i, .rstn_i, .rx_master_i, .rx_slave_clock_select_i, .tx_master_i,
  .rx_mux_i, .tx_mux_i, .rx_output_enable_i, .rx_sys_clock_i, .rx_sys_data_o, .rx_sys_data_oe_o,
  .rx_sys_signaling_oe_o, .rx_sys_clock_oe_o, .tx_sys_frame_pulse_oe_o, .mux_rx_data_a_o, .mux_rx_data_b_o,
  .mux_rx_signaling_a_o, .mux_rx_signaling_b_o, .mux_rx_oe_o, .core_rx_take_o, .core_tx_valid_o);
